/* rtl/upsc_ctrl.sv */
// Power state controller with APB register access
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module upsc_ctrl
  import upsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic usb_power_detect_i,
  input wire logic self_powered_i,
  input wire logic reset_pin_n_i,
  input wire logic phy_operational_i,
  input wire logic [GPIO_W-1:0] gpio_i,
  input wire logic usb_suspend_i,
  input wire logic usb_resume_i,
  input wire logic usb_reset_i,
  input wire logic set_config_i,
  input wire logic deconfig_i,
  input wire logic wol_event_i,
  input wire logic eee_receive_wake_flag_i,
  input wire logic eee_transmit_wake_flag_i,
  input wire logic frame_good_i,
  input wire logic frame_pass_i,
  output logic [2:0] power_state_o,
  output logic osc_enable_o,
  output logic pll_enable_o,
  output logic clk_out_enable_o,
  output logic phy_reset_o,
  output logic phy_enable_o,
  output logic usb_afe_enable_o,
  output logic ready_o,
  output logic rx_fifo_write_o,
  output logic remote_wake_o,
  output logic reinit_o
);
  typedef struct packed {
    upsc_pstate_t pst;
    logic from_cfg;
    logic [1:0] boot;
    logic [1:0] sel;
    logic [GPIO_W-1:0] gpio_wen;
    logic eee_rx_en;
    logic fw_en;
    logic reinit_flag;
    logic ready;
    logic capture;
    logic fifo_wr;
    logic wake;
    logic reinit_pls;
    logic osc;
    logic pll;
    logic phy_rst;
    logic phy_en;
    logic afe;
    logic ack;
    logic [31:0] rdata;
    logic err;
  } upsc_regs_t;

  localparam upsc_regs_t REG_RST = '{pst: PS_UNPOW, sel: SEL_RST, default: '0};

  upsc_regs_t q;
  upsc_regs_t d;
  logic [SYNC_W-1:0] sync;
  logic pwr_s;
  logic self_s;
  logic rstn_s;
  logic phy_s;
  logic [GPIO_W-1:0] gpio_s;
  logic pwr_ok;
  logic rst_evt;
  logic gpio_hit;
  logic eee_hit;
  logic frame_hit;
  logic acc;
  logic wr_en;
  logic [31:0] rd;
  logic rd_err;

  upsc_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({gpio_i, phy_operational_i, reset_pin_n_i, self_powered_i,
              usb_power_detect_i}),
    .sync_o(sync)
  );

  assign pwr_s = sync[SI_PWR];
  assign self_s = sync[SI_SELF];
  assign rstn_s = sync[SI_RSTN];
  assign phy_s = sync[SI_PHY];
  assign gpio_s = sync[SI_GPIO +: GPIO_W];

  // Bus-powered parts tie detect high, so only self-powered loss counts
  assign pwr_ok = pwr_s | ~self_s;
  assign rst_evt = usb_reset_i | ~rstn_s;
  assign gpio_hit = |(gpio_s & q.gpio_wen);
  assign eee_hit = (eee_receive_wake_flag_i & q.eee_rx_en) | eee_transmit_wake_flag_i; // [R20]
  assign frame_hit = frame_good_i & q.fw_en; // [R22]
  assign acc = psel_i & penable_i;

  // Read mux and decode, sampled into the wait-state cycle
  always_comb
  begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_i)
      ADDR_PMC:
      begin
        rd[PMC_SEL_LSB +: 2] = q.sel;
        rd[PMC_READY_BIT] = q.ready;
        rd[PMC_REINIT_BIT] = q.reinit_flag;
      end
      ADDR_STAT:
      begin
        rd[2:0] = q.pst;
        rd[STAT_CAP_BIT] = q.capture;
        rd[STAT_CFG_BIT] = q.from_cfg;
      end
      ADDR_WEN:
      begin
        rd[WEN_GPIO_LSB +: GPIO_W] = q.gpio_wen;
        rd[WEN_EEE_BIT] = q.eee_rx_en;
        rd[WEN_FW_BIT] = q.fw_en;
      end
      default: rd_err = 1'b1;
    endcase
  end

  assign wr_en = acc & q.ack & pwrite_i & ~q.err;

  always_comb
  begin
    d = q;
    d.wake = 1'b0;
    d.reinit_pls = 1'b0;
    d.fifo_wr = 1'b0;
    d.ack = acc & ~q.ack;
    d.err = 1'b0;
    if (acc && !q.ack)
    begin
      d.rdata = pwrite_i ? 32'h0000_0000 : rd;
      d.err = rd_err;
    end
    if (wr_en)
    begin
      case (paddr_i)
        ADDR_PMC:
        begin
          d.sel = pwdata_i[PMC_SEL_LSB +: 2];
          if (pwdata_i[PMC_REINIT_BIT])
          begin
            d.reinit_flag = 1'b0;
          end
        end
        ADDR_WEN:
        begin
          d.gpio_wen = pwdata_i[WEN_GPIO_LSB +: GPIO_W];
          d.eee_rx_en = pwdata_i[WEN_EEE_BIT];
          d.fw_en = pwdata_i[WEN_FW_BIT];
        end
        default: d.sel = q.sel;
      endcase
    end
    // Frames after the waking one keep flowing until the host resumes
    if (q.capture && frame_pass_i)
    begin
      d.fifo_wr = 1'b1; // [R21]
    end
    if (usb_resume_i && (q.pst == PS_CFG || q.pst == PS_UNCFG))
    begin
      d.capture = 1'b0;
    end
    // Strap and detect are only trusted once the synchroniser has filled
    if (q.boot != BOOT_WAIT)
    begin
      d.boot = q.boot + 2'h1;
    end
    else if (!pwr_ok)
    begin
      d.pst = PS_UNPOW; // [R23]
      d.capture = 1'b0;
    end
    else if (rst_evt && q.pst != PS_UNPOW)
    begin
      d.pst = PS_UNCFG; // [R14]
      d.reinit_pls = 1'b1;
      d.sel = SEL_RST;
      d.gpio_wen = '0;
      d.eee_rx_en = 1'b0;
      d.fw_en = 1'b0;
      d.capture = 1'b0;
      d.fifo_wr = 1'b0;
    end
    else
    begin
      case (q.pst)
        PS_UNPOW: d.pst = PS_UNCFG; // [R01] [R06]
        PS_UNCFG:
        begin
          // Only L2 and U3 arrive here; U1/U2/L1 never suspend [R13]
          if (usb_suspend_i)
          begin
            d.pst = PS_SDEEP; // [R09] [R11]
            d.from_cfg = 1'b0;
          end
          else if (set_config_i)
          begin
            d.pst = PS_CFG; // [R04]
          end
        end
        PS_CFG:
        begin
          if (usb_suspend_i)
          begin
            d.from_cfg = 1'b1;
            case (q.sel) // [R10]
              SEL_WOL: d.pst = PS_SWOL; // [R15]
              SEL_FCAP: d.pst = PS_SFCAP;
              default: d.pst = PS_SDEEP;
            endcase
          end
          else if (deconfig_i)
          begin
            d.pst = PS_UNCFG; // [R04]
            d.sel = SEL_RST; // [R12]
          end
        end
        PS_SWOL:
        begin
          if (usb_resume_i || wol_event_i || gpio_hit || eee_hit)
          begin
            d.pst = PS_CFG; // [R02] [R17]
            d.wake = ~usb_resume_i;
          end
        end
        PS_SDEEP:
        begin
          if (usb_resume_i || gpio_hit)
          begin
            d.pst = q.from_cfg ? PS_CFG : PS_UNCFG; // [R18] [R11]
            d.wake = ~usb_resume_i;
            // Host is told to rebuild PHY state; set wins over clear [R08]
            d.reinit_flag = 1'b1;
          end
        end
        PS_SFCAP:
        begin
          if (usb_resume_i || wol_event_i || gpio_hit || eee_hit || frame_hit)
          begin
            d.pst = PS_CFG; // [R02] [R20]
            d.wake = ~usb_resume_i;
            if (wol_event_i || frame_hit)
            begin
              d.capture = 1'b1; // [R21] [R22]
              d.fifo_wr = 1'b1;
            end
          end
        end
        default: d.pst = PS_UNPOW;
      endcase
    end
    // Ready waits for the PHY after every entry to configured [R07]
    d.ready = (d.pst == PS_CFG) && phy_s;
    d.osc = (d.pst != PS_UNPOW); // [R16] [R23]
    d.pll = (d.pst == PS_CFG) || (d.pst == PS_UNCFG) || (d.pst == PS_SFCAP); // [R05]
    d.phy_rst = (d.pst == PS_UNPOW) || (d.pst == PS_UNCFG) || (d.pst == PS_SDEEP); // [R03]
    d.phy_en = (d.pst == PS_CFG) || (d.pst == PS_SWOL) || (d.pst == PS_SFCAP);
    d.afe = (d.pst == PS_CFG) || (d.pst == PS_UNCFG); // [R19]
  end

  // Reference clock never stops, so wake logic works with PLLs down [R24]
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      q <= REG_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = q.ack;
  assign pslverr_o = q.err;
  assign power_state_o = q.pst;
  assign osc_enable_o = q.osc;
  assign pll_enable_o = q.pll;
  assign clk_out_enable_o = q.pll;
  assign phy_reset_o = q.phy_rst;
  assign phy_enable_o = q.phy_en;
  assign usb_afe_enable_o = q.afe;
  assign ready_o = q.ready;
  assign rx_fifo_write_o = q.fifo_wr;
  assign remote_wake_o = q.wake;
  assign reinit_o = q.reinit_pls;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_live;
    q.boot == BOOT_WAIT && pwr_ok && !rst_evt;
  endsequence
  sequence s_uncfg_cfg_req;
    q.pst == PS_UNCFG && set_config_i && !usb_suspend_i;
  endsequence
  sequence s_fcap_frame;
    q.pst == PS_SFCAP && wol_event_i;
  endsequence

  chk_unpow_exit: assert property ( // [R01]
    q.pst == PS_UNPOW ##0 s_live |=> q.pst == PS_UNCFG ##0 q.phy_rst)
    else $error("unpowered did not leave on power");
  // Power may return the next cycle, so only one held cycle is promised
  chk_boot_hold: assert property ( // [R06]
    q.boot == BOOT_WAIT && q.pst == PS_UNPOW && self_s && !pwr_s
      |=> q.pst == PS_UNPOW && !q.phy_en)
    else $error("self-powered part left unpowered without power");
  chk_uncfg_phy: assert property ( // [R03]
    q.pst == PS_UNCFG |-> q.phy_rst && !q.phy_en)
    else $error("PHY not held in reset while unconfigured");
  chk_cfg_entry: assert property ( // [R04]
    s_live ##0 s_uncfg_cfg_req |=> q.pst == PS_CFG)
    else $error("configuration request ignored");
  chk_cfg_clocks: assert property ( // [R05]
    q.pst == PS_CFG |-> q.pll && q.osc && q.afe && q.phy_en && clk_out_enable_o)
    else $error("configured state missing a clock or block");
  chk_ready_gate: assert property ( // [R07]
    $rose(q.ready) |-> q.pst == PS_CFG && $past(phy_s))
    else $error("ready raised without operational PHY");
  chk_deep_uncfg: assert property ( // [R11]
    s_live ##0 q.pst == PS_UNCFG && usb_suspend_i |=> q.pst == PS_SDEEP ##0 !q.from_cfg)
    else $error("unconfigured suspend not deepest");
  chk_sel_deconf: assert property ( // [R12]
    s_live ##0 q.pst == PS_CFG && deconfig_i && !usb_suspend_i
      |=> q.sel == SEL_RST && q.pst == PS_UNCFG)
    else $error("suspend select not reset on deconfigure");
  chk_reset_evt: assert property ( // [R14]
    q.boot == BOOT_WAIT && pwr_ok && rst_evt && q.pst != PS_UNPOW
      |=> q.pst == PS_UNCFG && q.reinit_pls)
    else $error("reset did not reinitialise to unconfigured");
  chk_wol_clocks: assert property ( // [R16]
    q.pst == PS_SWOL |-> !q.pll && q.osc && q.phy_en)
    else $error("WoL suspend clocking wrong");
  chk_deep_gpio: assert property ( // [R18]
    s_live ##0 q.pst == PS_SDEEP && !usb_resume_i && !gpio_hit |=> q.pst == PS_SDEEP)
    else $error("deep suspend woke on a non-GPIO source");
  chk_fcap_afe: assert property ( // [R19]
    q.pst == PS_SFCAP |-> !q.afe && q.pll)
    else $error("frame-capture suspend front ends still powered");
  chk_wake_frame: assert property ( // [R21]
    s_live ##0 s_fcap_frame |=> q.fifo_wr && q.capture && q.pst == PS_CFG)
    else $error("waking frame not stored");
  chk_unpow_drop: assert property ( // [R23]
    q.boot == BOOT_WAIT && self_s && !pwr_s |=> q.pst == PS_UNPOW && !q.osc && !q.pll)
    else $error("power loss did not shut down");
endmodule

/* rtl/upsc_pkg.sv */
// Constants and types of the USB power state controller
// Function
// [R01] Leave unpowered for normal-unconfigured once USB power is detected.
// [R02] Any suspend returns to normal on host resume, U0 or enabled wake.
// [R03] Hold the Ethernet PHY in reset while normal-unconfigured.
// [R04] Host configuration request configures; deconfiguring request returns to unconfigured.
// [R05] Normal-configured enables every clock, PLL and analog block.
// [R06] After system reset go unconfigured, unless self-powered without USB power.
// [R07] Keep USB context on wake; ready flag only once PHY operational.
// [R08] Host must reinitialise PHY registers after leaving the deepest suspend.
// [R09] Enter suspend on USB 2.0 suspend (L2) or link U3.
// [R10] Suspend only from normal; suspend-select field picks the variant.
// [R11] Unconfigured suspends only to deepest variant and returns unconfigured.
// [R12] Deconfiguration resets suspend-select to 10b.
// [R13] Suspend-select ignores U1/U2 link states and LPM L1.
// [R14] USB reset or reset pin reinitialises any suspend into unconfigured.
// [R15] Encoding 00b selects Wake-on-LAN variant; its alternate behaves identically. Here 01b enters the deepest variant instead.
// [R16] Wake-on-LAN variant stops PLLs, keeps oscillator for MAC and PHY.
// [R17] Wake-on-LAN event restarts the link PLL and output clocks.
// [R18] Deepest variant 10b is default, least power, GPIO-only remote wake.
// [R19] Frame-capture variant 11b keeps clocks, powers down USB front ends.
// [R20] Frame-capture also wakes on enabled EEE receive or EEE transmit wake.
// [R21] Frame-capture stores the waking frame and later passing frames in FIFO.
// [R22] With filter wake enabled, any good filtered frame wakes and is stored.
// [R23] USB power loss enters unpowered: oscillator, PLLs and PHY off.
// [R24] State logic runs on the always-on reference clock.
// [R25] Each power state and suspend variant is its own encoded state.
package upsc_pkg;
  localparam logic [11:0] ADDR_PMC = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_WEN = 12'h008;
  localparam int PMC_SEL_LSB = 0;
  localparam int PMC_READY_BIT = 4;
  localparam int PMC_REINIT_BIT = 8;
  localparam int WEN_GPIO_LSB = 0;
  localparam int WEN_EEE_BIT = 8;
  localparam int WEN_FW_BIT = 9;
  localparam int STAT_CAP_BIT = 3;
  localparam int STAT_CFG_BIT = 4;
  localparam logic [1:0] SEL_WOL = 2'h0;
  localparam logic [1:0] SEL_WOL_ALT = 2'h0;
  localparam logic [1:0] SEL_DEEP = 2'h2;
  localparam logic [1:0] SEL_FCAP = 2'h3;
  localparam logic [1:0] SEL_RST = SEL_DEEP;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam int GPIO_W = 8;
  localparam int SYNC_W = 12;
  localparam int SI_PWR = 0;
  localparam int SI_SELF = 1;
  localparam int SI_RSTN = 2;
  localparam int SI_PHY = 3;
  localparam int SI_GPIO = 4;

  // [R25]
  typedef enum logic [2:0] {
    PS_UNPOW = 3'b000,
    PS_UNCFG = 3'b001,
    PS_CFG = 3'b010,
    PS_SWOL = 3'b011,
    PS_SDEEP = 3'b100,
    PS_SFCAP = 3'b101
  } upsc_pstate_t;
endpackage

/* rtl/upsc_sync.sv */
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
module upsc_sync
  import upsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [SYNC_W-1:0] async_i,
  output logic [SYNC_W-1:0] sync_o
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } upsc_sync_t;

  upsc_sync_t q;
  upsc_sync_t d;

  always_comb
  begin
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule

/* tb/upsc_host.sv */
// Host model issuing USB suspend, resume, reset and configuration requests
`timescale 1ns/1ns
module upsc_host
(
  input wire logic clock_i,
  output logic usb_suspend_o,
  output logic usb_resume_o,
  output logic usb_reset_o,
  output logic set_config_o,
  output logic deconfig_o
);
  logic [4:0] req_q = 5'h00;
  assign {usb_suspend_o, usb_resume_o, usb_reset_o, set_config_o, deconfig_o} = req_q;
  // One-cycle request; gap models a slow host between requests
  task automatic send(input int idx, input int gap);
    @(posedge clock_i);
    req_q <= 5'(5'h01 << idx);
    @(posedge clock_i);
    req_q <= 5'h00;
    repeat (gap) @(posedge clock_i);
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking testbench of the USB power state controller
`timescale 1ns/1ns
module testbench
  import upsc_pkg::*;
;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic usb_power_detect_i = 1'h1;
  logic self_powered_i = 1'h0;
  logic reset_pin_n_i = 1'h1;
  logic phy_operational_i = 1'h0;
  logic [GPIO_W-1:0] gpio_i = 8'h00;
  logic [4:0] ev_q = 5'h00;
  logic usb_suspend_i, usb_resume_i, usb_reset_i, set_config_i, deconfig_i;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, osc_enable_o, pll_enable_o, clk_out_enable_o, phy_reset_o;
  logic phy_enable_o, usb_afe_enable_o, ready_o, rx_fifo_write_o, remote_wake_o, reinit_o;
  logic [2:0] power_state_o;
  logic [31:0] rd;
  logic er;
  logic [1:0] sel;
  logic [2:0] st;
  logic [1:0] tbl [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3};
  int n_fail = 0;
  int check_count = 0;
  int rw_n = 0;
  int fw_n = 0;
  int ri_n = 0;
  int base;

  upsc_host i_upsc_host (.clock_i(clock_i), .usb_suspend_o(usb_suspend_i),
    .usb_resume_o(usb_resume_i), .usb_reset_o(usb_reset_i), .set_config_o(set_config_i),
    .deconfig_o(deconfig_i));

  upsc_ctrl i_upsc_ctrl (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .usb_power_detect_i(usb_power_detect_i), .self_powered_i(self_powered_i),
    .reset_pin_n_i(reset_pin_n_i), .phy_operational_i(phy_operational_i),
    .gpio_i(gpio_i), .usb_suspend_i(usb_suspend_i), .usb_resume_i(usb_resume_i),
    .usb_reset_i(usb_reset_i), .set_config_i(set_config_i), .deconfig_i(deconfig_i),
    .wol_event_i(ev_q[0]), .eee_receive_wake_flag_i(ev_q[4]),
    .eee_transmit_wake_flag_i(ev_q[1]), .frame_good_i(ev_q[2]), .frame_pass_i(ev_q[3]),
    .power_state_o(power_state_o), .osc_enable_o(osc_enable_o),
    .pll_enable_o(pll_enable_o), .clk_out_enable_o(clk_out_enable_o),
    .phy_reset_o(phy_reset_o), .phy_enable_o(phy_enable_o),
    .usb_afe_enable_o(usb_afe_enable_o), .ready_o(ready_o),
    .rx_fifo_write_o(rx_fifo_write_o), .remote_wake_o(remote_wake_o), .reinit_o(reinit_o));

  always #25 clock_i = ~clock_i;

  // Pulse outputs last one cycle per event, reinit_o as long as a reset holds, so they are counted rather than polled
  always @(posedge clock_i)
  begin
    rw_n <= rw_n + int'(remote_wake_o === 1'h1);
    fw_n <= fw_n + int'(rx_fifo_write_o === 1'h1);
    ri_n <= ri_n + int'(reinit_o === 1'h1);
  end

  function automatic logic [2:0] exp_susp(input logic [1:0] s, input logic c);
    if (!c || s == SEL_DEEP || s == 2'h1)
      return PS_SDEEP;
    return (s == SEL_FCAP) ? PS_SFCAP : PS_SWOL;
  endfunction

  function automatic logic [3:0] exp_en(input logic [2:0] s);
    case (s)
      PS_SWOL, PS_SDEEP: return 4'h8;
      PS_SFCAP: return 4'he;
      default: return 4'hf;
    endcase
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    @(posedge clock_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'h1;
    // Only the watchdog ends a wait for the slave
    do
    begin
      @(posedge clock_i);
    end
    while (pready_o !== 1'h1);
    rdv = prdata_o;
    erv = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic ev_pulse(input int k);
    @(posedge clock_i);
    ev_q <= 5'(5'h01 << k);
    @(posedge clock_i);
    ev_q <= 5'h00;
  endtask

  // Pins add synchroniser delay, so the wait is bounded, not exact
  task automatic wait_st(input logic [2:0] exp);
    int n;
    n = 0;
    while (power_state_o !== exp && n < 12)
    begin
      @(posedge clock_i);
      n++;
    end
    cmp(32'(power_state_o), 32'(exp));
  endtask

  task automatic chk_en(input logic [2:0] s);
    cmp(32'({osc_enable_o, pll_enable_o, clk_out_enable_o, usb_afe_enable_o}), 32'(exp_en(s)));
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    n_fail++;
    complete_run;
  end

  initial
  begin
    base = $urandom(96);
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    wait_st(PS_UNCFG);
    cmp(32'(phy_reset_o), 32'h1);
    apb(1'h0, ADDR_PMC, 32'h0000_0000, rd, er);
    cmp(32'(rd[1:0]), 32'(SEL_DEEP));
    apb(1'h0, 12'h00c, 32'h0000_0000, rd, er);
    cmp(32'(er), 32'h1);
    phy_operational_i <= 1'h1;
    i_upsc_host.send(1, 0);
    wait_st(PS_CFG);
    repeat (5) @(posedge clock_i);
    chk_en(PS_CFG);
    cmp(32'(ready_o), 32'h1);
    apb(1'h1, ADDR_WEN, 32'h0000_01ff, rd, er);
    $display("test boot done");
    for (int i = 0; i < 8; i++)
    begin
      sel = (i < 5) ? tbl[i] : 2'($urandom);
      st = exp_susp(sel, 1'h1);
      apb(1'h1, ADDR_PMC, 32'(sel), rd, er);
      base = rw_n;
      i_upsc_host.send(4, 0);
      wait_st(st);
      chk_en(st);
      if (i[0])
        i_upsc_host.send(3, 0);
      else if (st == PS_SWOL)
        ev_pulse(0);
      else if (st == PS_SFCAP)
        ev_pulse(i[2] ? 1 : 4);
      else
        gpio_i <= 8'(8'h01 << ($urandom % 8));
      wait_st(PS_CFG);
      gpio_i <= 8'h00;
      repeat (3) @(posedge clock_i);
      cmp(32'(rw_n - base), 32'(!i[0]));
      chk_en(PS_CFG);
      cmp(32'(ready_o), 32'h1);
    end
    $display("test suspend variants done");
    apb(1'h0, ADDR_PMC, 32'h0000_0000, rd, er);
    cmp(32'(rd[8]), 32'h1);
    apb(1'h1, ADDR_PMC, 32'h0000_0103, rd, er);
    apb(1'h0, ADDR_PMC, 32'h0000_0000, rd, er);
    cmp(32'(rd[8]), 32'h0);
    apb(1'h1, ADDR_WEN, 32'h0000_0200, rd, er);
    base = fw_n;
    i_upsc_host.send(4, 0);
    wait_st(PS_SFCAP);
    ev_pulse(2);
    wait_st(PS_CFG);
    ev_pulse(3);
    repeat (2) @(posedge clock_i);
    cmp(32'(fw_n - base), 32'h2);
    // EEE receive wake is disabled now, so only the Wake-on-LAN frame wakes
    base = fw_n;
    i_upsc_host.send(4, 0);
    wait_st(PS_SFCAP);
    ev_pulse(4);
    repeat (3) @(posedge clock_i);
    cmp(32'(power_state_o), 32'(PS_SFCAP));
    ev_pulse(0);
    wait_st(PS_CFG);
    repeat (2) @(posedge clock_i);
    cmp(32'(fw_n - base), 32'h1);
    $display("test frame capture done");
    i_upsc_host.send(0, 0);
    wait_st(PS_UNCFG);
    apb(1'h0, ADDR_PMC, 32'h0000_0000, rd, er);
    cmp(32'(rd[1:0]), 32'(SEL_DEEP));
    apb(1'h1, ADDR_PMC, 32'(SEL_FCAP), rd, er);
    i_upsc_host.send(4, 2);
    wait_st(PS_SDEEP);
    i_upsc_host.send(3, 0);
    wait_st(PS_UNCFG);
    base = ri_n;
    i_upsc_host.send(4, 0);
    wait_st(PS_SDEEP);
    i_upsc_host.send(2, 0);
    wait_st(PS_UNCFG);
    i_upsc_host.send(4, 0);
    wait_st(PS_SDEEP);
    reset_pin_n_i <= 1'h0;
    wait_st(PS_UNCFG);
    reset_pin_n_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    cmp(32'(ri_n - base > 1), 32'h1);
    $display("test resets done");
    self_powered_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    usb_power_detect_i <= 1'h0;
    wait_st(PS_UNPOW);
    cmp(32'({osc_enable_o, pll_enable_o, phy_enable_o}), 32'h0);
    // System reset of a self-powered part without USB power stays unpowered
    rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    repeat (8) @(posedge clock_i);
    cmp(32'(power_state_o), 32'(PS_UNPOW));
    cmp(32'(osc_enable_o), 32'h0);
    usb_power_detect_i <= 1'h1;
    wait_st(PS_UNCFG);
    $display("test power done");
    complete_run;
  end
endmodule
